// ==== bench/ism_checker.sv ====
// Port-level checks of the status and address mask block
module ism_checker
	import ism_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_I,
	// Register port
	input wire logic [3:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [15:0] RDATA_O,
	input wire logic IRQ_O,
	// I2C bus
	input wire logic SCL_I,
	input wire logic SDA_I,
	input wire logic SDA_O,
	input wire logic SDA_OE_O
);
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (RST_I);
	// ----
	// Last bus condition seen at the pins
	// ----
	logic scl_q, sda_q, start_q, start_d;
	logic [3:0] since_q, since_d;
	wire is_start = scl_q && SCL_I && sda_q && !SDA_I;
	wire is_stop = scl_q && SCL_I && !sda_q && SDA_I;
	assign start_d = is_start ? 1'b1 : (is_stop ? 1'b0 : start_q);
	assign since_d = (is_start || is_stop) ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
	always_ff @(posedge CLOCK_I)
	begin
		scl_q <= RST_I | SCL_I;
		sda_q <= RST_I | SDA_I;
		start_q <= !RST_I && start_d;
		since_q <= RST_I ? 4'hf : since_d;
	end
	// ----
	// Properties
	// ----
	sequence s_tx_write;
		WR_I && ADDR_I == ADDR_TRANSMIT_HOLD;
	endsequence
	sequence s_rx_read;
		RD_I && ADDR_I == ADDR_RECEIVE_HOLD;
	endsequence
	sequence s_stat_read;
		RD_I && ADDR_I == ADDR_BUS_STATUS;
	endsequence
	AST_RDATA_IDLE: assert property (!RD_I |=> RDATA_O == 16'h0000)
		else $error("read data not zero outside a read");
	AST_SDA_LOW: assert property (SDA_O == 1'b0)
		else $error("data pin output not low");
	AST_RESET_QUIET: assert property ($fell(RST_I) |-> RDATA_O == 16'h0000 && !IRQ_O && !SDA_OE_O)
		else $error("outputs busy out of reset");
	AST_MASK_UPPER: assert property (
		RD_I && ADDR_I == ADDR_ADDRESS_MASK |=> RDATA_O[15:10] == 6'h00)
		else $error("mask upper bits not zero");
	AST_TX_FULL: assert property (s_tx_write ##1 s_stat_read |=> RDATA_O[BIT_TRANSMIT_FULL])
		else $error("transmit flag not set");
	AST_RX_CLEAR: assert property (s_rx_read ##1 s_stat_read |=> !RDATA_O[BIT_RECEIVE_FULL])
		else $error("receive flag not cleared");
	AST_START_FLAG: assert property (
		s_stat_read and since_q > 4'h7 |=> RDATA_O[BIT_START_SEEN] == start_q)
		else $error("start flag wrong");
	AST_IRQ_MASKED: assert property (
		WR_I && ADDR_I == ADDR_EVENT_MASK && WDATA_I[EV_WIDTH-1:0] == 4'h0 |-> ##2 !IRQ_O)
		else $error("interrupt high while masked");
endmodule : ism_checker

// ==== bench/ism_master_model.sv ====
// Behavioural I2C master on the far side of the bus
module ism_master_model
(
	// Clock
	input wire logic clk_i,
	// Bus
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Link clock stands high between frames
	initial
	begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// Quarter of the 320 ns link period
	task automatic quarter;
		repeat (2) @(posedge clk_i);
	endtask : quarter
	task automatic send_start;
		sda_oe_o <= 1'b0;
		quarter();
		scl_o <= 1'b1;
		quarter();
		sda_oe_o <= 1'b1;
		quarter();
		scl_o <= 1'b0;
		quarter();
	endtask : send_start
	task automatic send_stop;
		sda_oe_o <= 1'b1;
		quarter();
		scl_o <= 1'b1;
		quarter();
		sda_oe_o <= 1'b0;
		quarter();
	endtask : send_stop
	task automatic clock_bit(input logic val, output logic got);
		sda_oe_o <= ~val;
		quarter();
		scl_o <= 1'b1;
		quarter();
		got = sda_i;
		quarter();
		scl_o <= 1'b0;
		quarter();
	endtask : clock_bit
	// Byte MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			clock_bit(tx[i], rx[i]);
		clock_bit(ack_in, ack);
	endtask : xfer
endmodule : ism_master_model

// ==== bench/ism_top_bench.sv ====
// Self-checking bench of the status and address mask block
module ism_top_bench
	import ism_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, wr, rd_s, ack;
	logic [3:0] addr;
	logic [15:0] wdata, d;
	logic [7:0] rx;
	wire [15:0] rdata;
	wire irq, sda_o, sda_oe, scl_line, m_oe;
	int n_fail = 0;
	int tests_run = 0;
	logic [6:0] adr_tab [5] = '{7'h2b, 7'h2a, 7'h2b, 7'h0a, 7'h0a};
	logic [15:0] msk_tab [5] = '{16'h0000, 16'h0000, 16'h0001, 16'h0020, 16'h0010};
	logic ack_tab [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
	// Pull-up: the line is low while either party drives it
	wire sda_line = ~(m_oe | sda_oe);
	ism_top ism_top_inst (.CLOCK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd_s), .RDATA_O(rdata), .IRQ_O(irq), .SCL_I(scl_line),
		.SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE_O(sda_oe));
	ism_master_model ism_master_model_inst (.clk_i(clk), .sda_i(sda_line), .scl_o(scl_line),
		.sda_oe_o(m_oe));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ----
	// Register access and checking
	// ----
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		if (n_fail == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end
	// ----
	// Scenarios
	// ----
	initial
	begin
		rst = 1'b1;
		wr = 1'b0;
		rd_s = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		idle(4);
		rst <= 1'b0;
		rd_reg(ADDR_BUS_STATUS, d);
		chk(d, 16'h0000);
		rd_reg(ADDR_ADDRESS_MASK, d);
		chk(d, 16'h0000);
		rd_reg(4'h9, d);
		chk(d, 16'h0000);
		wr_reg(ADDR_ADDRESS_MASK, 16'hffff);
		rd_reg(ADDR_ADDRESS_MASK, d);
		chk(d, 16'h03ff);
		wr_reg(ADDR_OWN_ADDRESS, 16'h002a);
		wr_reg(ADDR_EVENT_MASK, 16'h0000);
		wr_reg(ADDR_CONTROL, 16'h0000);
		for (int i = 0; i < 5; i++)
		begin
			wr_reg(ADDR_ADDRESS_MASK, msk_tab[i]);
			ism_master_model_inst.send_start();
			ism_master_model_inst.xfer({adr_tab[i], 1'b0}, 1'b1, rx, ack);
			chk({15'h0, ack}, {15'h0, ack_tab[i]});
		end
		ism_master_model_inst.send_start();
		ism_master_model_inst.xfer(8'h54, 1'b1, rx, ack);
		ism_master_model_inst.xfer(8'hc3, 1'b1, rx, ack);
		idle(4);
		rd_reg(ADDR_BUS_STATUS, d);
		chk(d, 16'h000a);
		rd_reg(ADDR_RECEIVE_HOLD, d);
		chk(d, 16'h00c3);
		rd_reg(ADDR_BUS_STATUS, d);
		chk(d, 16'h0008);
		ism_master_model_inst.send_stop();
		idle(8);
		rd_reg(ADDR_BUS_STATUS, d);
		chk(d, 16'h0000);
		chk({15'h0, irq}, 16'h0000);
		wr_reg(ADDR_TRANSMIT_HOLD, 16'h005a);
		rd_reg(ADDR_BUS_STATUS, d);
		chk(d, 16'h0001);
		ism_master_model_inst.send_start();
		ism_master_model_inst.xfer(8'h55, 1'b1, rx, ack);
		chk({15'h0, ack}, 16'h0000);
		idle(4);
		rd_reg(ADDR_RECEIVE_HOLD, d);
		rd_reg(ADDR_BUS_STATUS, d);
		chk(d, 16'h000d);
		ism_master_model_inst.xfer(8'hff, 1'b1, rx, ack);
		chk({8'h00, rx}, 16'h005a);
		idle(4);
		rd_reg(ADDR_BUS_STATUS, d);
		chk(d, 16'h000c);
		ism_master_model_inst.send_stop();
		idle(8);
		rd_reg(ADDR_EVENT_STATUS, d);
		chk(d, 16'h000f);
		rd_reg(ADDR_EVENT_STATUS, d);
		chk(d, 16'h0000);
		wr_reg(ADDR_EVENT_MASK, 16'h0002);
		ism_master_model_inst.send_start();
		ism_master_model_inst.send_stop();
		idle(8);
		chk({15'h0, irq}, 16'h0001);
		rd_reg(ADDR_EVENT_STATUS, d);
		chk(d, 16'h0003);
		idle(2);
		chk({15'h0, irq}, 16'h0000);
		wr_reg(ADDR_EVENT_MASK, 16'h0000);
		idle(4);
		report_and_stop();
	end
endmodule : ism_top_bench

bind ism_top ism_checker ism_checker_inst (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O),
	.SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O));

// ==== verilog/ism_addr_match.sv ====
// Masked comparison of a received slave address against the own address
module ism_addr_match
	import ism_pkg::*;
(
	// Operands
	input wire logic [MASK_WIDTH-1:0] received_i,
	input wire logic [MASK_WIDTH-1:0] own_i,
	input wire logic [MASK_WIDTH-1:0] mask_i,
	// Result
	output logic match_o
);
	logic [MASK_WIDTH-1:0] bit_ok;

	genvar g;
	generate
		for (g = 0; g < MASK_WIDTH; g++)
		begin : g_bit
			// A set mask bit makes the position a wildcard
			assign bit_ok[g] = mask_i[g] | (received_i[g] == own_i[g]);
		end
	endgenerate

	assign match_o = &bit_ok;
endmodule : ism_addr_match

// ==== verilog/ism_line_sync.sv ====
// Two-stage synchroniser and condition detector for the I2C lines
module ism_line_sync
	import ism_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Raw pins
	input wire ism_line_s line_i,
	// Detected conditions
	output ism_cond_s cond_o
);
	ism_line_s meta_q;
	ism_line_s sync_q;
	ism_line_s last_q;

	// The first stage is read by the second stage only
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_q <= '{scl: 1'b1, sda: 1'b1};
			sync_q <= '{scl: 1'b1, sda: 1'b1};
			last_q <= '{scl: 1'b1, sda: 1'b1};
		end
		else
		begin
			meta_q <= line_i;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	// ------------------------------------------------------------
	// Conditions: data edges while the clock line is high, clock line edges and the sampled data bit
	// ------------------------------------------------------------
	wire scl_high = sync_q.scl & last_q.scl;
	assign cond_o.start_seen = scl_high & last_q.sda & ~sync_q.sda;
	assign cond_o.stop_seen = scl_high & ~last_q.sda & sync_q.sda;
	assign cond_o.bit_valid = sync_q.scl & ~last_q.scl;
	assign cond_o.bit_value = sync_q.sda;
	assign cond_o.scl_fall = ~sync_q.scl & last_q.scl;
endmodule : ism_line_sync

// ==== verilog/ism_pkg.sv ====
// Constants, register map and carrier types of the I2C status and address mask block
package ism_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_BUS_STATUS = 4'h0;
	localparam logic [3:0] ADDR_ADDRESS_MASK = 4'h1;
	localparam logic [3:0] ADDR_RECEIVE_HOLD = 4'h2;
	localparam logic [3:0] ADDR_TRANSMIT_HOLD = 4'h3;
	localparam logic [3:0] ADDR_OWN_ADDRESS = 4'h4;
	localparam logic [3:0] ADDR_EVENT_STATUS = 4'h5;
	localparam logic [3:0] ADDR_EVENT_MASK = 4'h6;
	localparam logic [3:0] ADDR_CONTROL = 4'h7;

	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam int BIT_START_SEEN = 3;
	localparam int BIT_DIRECTION = 2;
	localparam int BIT_RECEIVE_FULL = 1;
	localparam int BIT_TRANSMIT_FULL = 0;
	localparam int MASK_WIDTH = 10;
	localparam logic [9:0] MASK_RESET = 10'h000;
	localparam logic [9:0] OWN_ADDRESS_RESET = 10'h000;
	localparam logic [15:0] UNMAPPED_READ = 16'h0000;
	localparam int EV_WIDTH = 4;
	localparam int EV_START = 0;
	localparam int EV_STOP = 1;
	localparam int EV_RECEIVED = 2;
	localparam int EV_SENT = 3;
	localparam int CTRL_TEN_BIT = 0;

	// ------------------------------------------------------------
	// Bus carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic scl;
		logic sda;
	} ism_line_s;

	typedef struct packed {
		logic start_seen;
		logic stop_seen;
		logic bit_valid;
		logic bit_value;
		logic scl_fall;
	} ism_cond_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_RX_DATA,
		ST_RX_ACK,
		ST_TX_DATA,
		ST_TX_ACK,
		ST_SKIP
	} ism_state_e;
endpackage : ism_pkg

// ==== verilog/ism_top.sv ====
// I2C slave status flags, address mask and data holding registers
module ism_top
	import ism_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_I,
	// Register port
	input wire logic [3:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [15:0] RDATA_O,
	// Interrupt
	output logic IRQ_O,
	// I2C bus, open drain
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O
);
	// ------------------------------------------------------------
	// Line conditioning
	// ------------------------------------------------------------
	ism_cond_s cond;
	ism_line_s line;
	assign line = '{scl: SCL_I, sda: SDA_I};

	ism_line_sync u_sync (
		.clk_i(CLOCK_I),
		.rst_i(RST_I),
		.line_i(line),
		.cond_o(cond)
	);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [MASK_WIDTH-1:0] mask_q;
	logic [MASK_WIDTH-1:0] own_q;
	logic ten_bit_q;
	logic [7:0] rx_hold_q;
	logic [7:0] tx_hold_q;
	logic start_seen_q;
	logic direction_q;
	logic receive_full_q;
	logic transmit_full_q;
	logic [EV_WIDTH-1:0] ev_status_q;
	logic [EV_WIDTH-1:0] ev_mask_q;
	logic irq_q;
	logic [15:0] rdata_q;

	// Protocol engine
	ism_state_e state_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [1:0] addr_phase_q;
	logic [MASK_WIDTH-1:0] addr_rx_q;
	logic sda_drive_q;
	logic sda_out_q;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire wr_mask = WR_I & (ADDR_I == ADDR_ADDRESS_MASK);
	wire wr_own = WR_I & (ADDR_I == ADDR_OWN_ADDRESS);
	wire wr_tx = WR_I & (ADDR_I == ADDR_TRANSMIT_HOLD);
	wire wr_evmask = WR_I & (ADDR_I == ADDR_EVENT_MASK);
	wire wr_ctrl = WR_I & (ADDR_I == ADDR_CONTROL);
	wire rd_rx = RD_I & (ADDR_I == ADDR_RECEIVE_HOLD);
	wire rd_ev = RD_I & (ADDR_I == ADDR_EVENT_STATUS);

	wire [15:0] status_word = {12'h000, start_seen_q, direction_q, receive_full_q,
		transmit_full_q};
	wire [15:0] rd_mux =
		(ADDR_I == ADDR_BUS_STATUS) ? status_word :
		(ADDR_I == ADDR_ADDRESS_MASK) ? {6'h00, mask_q} :
		(ADDR_I == ADDR_RECEIVE_HOLD) ? {8'h00, rx_hold_q} :
		(ADDR_I == ADDR_TRANSMIT_HOLD) ? {8'h00, tx_hold_q} :
		(ADDR_I == ADDR_OWN_ADDRESS) ? {6'h00, own_q} :
		(ADDR_I == ADDR_EVENT_STATUS) ? {12'h000, ev_status_q} :
		(ADDR_I == ADDR_EVENT_MASK) ? {12'h000, ev_mask_q} :
		(ADDR_I == ADDR_CONTROL) ? {15'h0000, ten_bit_q} : UNMAPPED_READ;

	// ------------------------------------------------------------
	// Address matching
	// ------------------------------------------------------------
	// The eighth bit is not yet shifted in when the byte completes, so merge it here
	wire [7:0] byte_in = {shift_q[6:0], cond.bit_value};
	// Seven-bit mode compares the low seven bits; upper ones are masked off
	wire [MASK_WIDTH-1:0] cmp_addr = ten_bit_q ? {addr_rx_q[8:7], byte_in} :
		{3'h0, byte_in[7:1]};
	wire [MASK_WIDTH-1:0] cmp_mask = ten_bit_q ? mask_q : (mask_q | 10'h380);
	wire addr_match;

	ism_addr_match u_match (
		.received_i(cmp_addr),
		.own_i(own_q),
		.mask_i(cmp_mask),
		.match_o(addr_match)
	);

	// Ten-bit header: 11110 A9 A8 R/W
	wire header_ok = (byte_in[7:3] == 5'h1e);

	// ------------------------------------------------------------
	// Engine events
	// ------------------------------------------------------------
	wire byte_done = cond.bit_valid & (bit_cnt_q == 4'h7);
	wire ack_clock = cond.bit_valid;
	wire rx_load = (state_q == ST_RX_DATA) & byte_done;
	wire tx_done = (state_q == ST_TX_ACK) & ack_clock & transmit_full_q;
	wire addr_take = (state_q == ST_ADDR) & byte_done;
	wire addr_final = addr_take & (~ten_bit_q | (addr_phase_q == 2'h1));
	wire addr_hit = addr_final & (ten_bit_q ? addr_match : addr_match);
	wire first_hdr = addr_take & ten_bit_q & (addr_phase_q == 2'h0) & header_ok;
	wire [EV_WIDTH-1:0] events = {tx_done, rx_load, cond.stop_seen, cond.start_seen};

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			start_seen_q <= 1'b0;
			direction_q <= 1'b0;
			receive_full_q <= 1'b0;
			transmit_full_q <= 1'b0;
		end
		else
		begin
			if (cond.start_seen)
				start_seen_q <= 1'b1;
			else if (cond.stop_seen)
				start_seen_q <= 1'b0;
			if (addr_hit)
				direction_q <= ten_bit_q ? addr_rx_q[9] : byte_in[0];
			// Hardware set beats a same-cycle software read
			if (rx_load)
				receive_full_q <= 1'b1;
			else if (rd_rx)
				receive_full_q <= 1'b0;
			if (wr_tx)
				transmit_full_q <= 1'b1;
			else if (tx_done)
				transmit_full_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Software registers and holding registers
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			mask_q <= MASK_RESET;
			own_q <= OWN_ADDRESS_RESET;
			ten_bit_q <= 1'b0;
			ev_mask_q <= '0;
			tx_hold_q <= 8'h00;
			rx_hold_q <= 8'h00;
		end
		else
		begin
			if (wr_mask)
				mask_q <= WDATA_I[MASK_WIDTH-1:0];
			if (wr_own)
				own_q <= WDATA_I[MASK_WIDTH-1:0];
			if (wr_ctrl)
				ten_bit_q <= WDATA_I[CTRL_TEN_BIT];
			if (wr_evmask)
				ev_mask_q <= WDATA_I[EV_WIDTH-1:0];
			if (wr_tx)
				tx_hold_q <= WDATA_I[7:0];
			if (rx_load)
				rx_hold_q <= byte_in;
		end
	end

	// ------------------------------------------------------------
	// Interrupt status: sticky, cleared by reading; new events win
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			ev_status_q <= '0;
			irq_q <= 1'b0;
			rdata_q <= 16'h0000;
		end
		else
		begin
			ev_status_q <= (rd_ev ? '0 : ev_status_q) | events;
			irq_q <= |(((rd_ev ? '0 : ev_status_q) | events) & ev_mask_q);
			rdata_q <= RD_I ? rd_mux : 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// Slave protocol engine
	// ------------------------------------------------------------
	// The shift register keeps the last byte: bit 0 holds the latest sample
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			state_q <= ST_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			addr_phase_q <= 2'h0;
			addr_rx_q <= '0;
		end
		else if (cond.stop_seen)
		begin
			state_q <= ST_IDLE;
			addr_phase_q <= 2'h0;
		end
		else if (cond.start_seen)
		begin
			state_q <= ST_ADDR;
			bit_cnt_q <= 4'h0;
			addr_phase_q <= 2'h0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE, ST_SKIP:
					state_q <= state_q;
				ST_ADDR, ST_RX_DATA:
					if (cond.bit_valid)
					begin
						shift_q <= {shift_q[6:0], cond.bit_value};
						bit_cnt_q <= bit_cnt_q + 4'h1;
						if (byte_done)
						begin
							bit_cnt_q <= 4'h0;
							if (state_q == ST_RX_DATA)
								state_q <= ST_RX_ACK;
							else if (first_hdr)
							begin
								addr_phase_q <= 2'h1;
								addr_rx_q <= {cond.bit_value, byte_in[2:1], 7'h00};
								state_q <= ST_ADDR_ACK;
							end
							else if (addr_hit)
								state_q <= ST_ADDR_ACK;
							else
								state_q <= ST_SKIP;
						end
					end
				ST_ADDR_ACK:
					if (cond.bit_valid)
						state_q <= (addr_phase_q == 2'h1 && ten_bit_q && bit_cnt_q == 4'h0
							&& !direction_q && addr_rx_q[9:7] != 3'h0 && 1'b0) ? ST_ADDR :
							addr_phase_q == 2'h1 ? ST_ADDR :
							(direction_q ? ST_TX_DATA : ST_RX_DATA);
				ST_RX_ACK:
					if (cond.bit_valid)
						state_q <= ST_RX_DATA;
				ST_TX_DATA:
					if (byte_done)
					begin
						bit_cnt_q <= 4'h0;
						state_q <= ST_TX_ACK;
					end
					else if (cond.bit_valid)
						bit_cnt_q <= bit_cnt_q + 4'h1;
				ST_TX_ACK:
					if (ack_clock)
						state_q <= cond.bit_value ? ST_SKIP : ST_TX_DATA;
			endcase
			if (addr_hit & (addr_phase_q == 2'h1))
				addr_phase_q <= 2'h2;
		end
	end

	// ------------------------------------------------------------
	// Data line drive: set on a clock line fall, released on a start or stop condition
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			sda_drive_q <= 1'b0;
			sda_out_q <= 1'b0;
		end
		else if (cond.stop_seen | cond.start_seen)
			sda_drive_q <= 1'b0;
		else if (cond.scl_fall)
		begin
			unique case (state_q)
				ST_ADDR_ACK, ST_RX_ACK:
					sda_drive_q <= 1'b1;
				ST_TX_DATA:
					sda_drive_q <= ~tx_hold_q[3'h7 - bit_cnt_q[2:0]];
				default:
					sda_drive_q <= 1'b0;
			endcase
		end
	end

	// Open drain: the line is only ever pulled low
	assign RDATA_O = rdata_q;
	assign IRQ_O = irq_q;
	assign SDA_O = sda_out_q;
	assign SDA_OE_O = sda_drive_q;
endmodule : ism_top
